/* core/ppc_defines.svh */
// Register indices, field positions, codes and reset values of the port.
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_IDX_EDGE 8'h00
`define PPC_IDX_PLL1 8'h01
`define PPC_IDX_PLL2 8'h02
`define PPC_IDX_PLL3 8'h03
`define PPC_IDX_OFFSET 8'h04
`define PPC_IDX_RES 8'h05
`define PPC_IDX_RESET 8'h08
`define PPC_IDX_VER 8'h10
`define PPC_IDX_REV 8'h11
`define PPC_IDX_STAT 8'h12
`define PPC_LAST_RW 4'h7
`define PPC_BIT_EDGE 2
`define PPC_BIT_FILTER 7
`define PPC_BIT_LOCK 1
`define PPC_CMD_DPA 4'hA
`define PPC_CMD_PLL 4'h5
`define PPC_RES_16 2'h0
`define PPC_RES_32 2'h1
`define PPC_RES_64 2'h3
`define PPC_MAX_16 6'h0F
`define PPC_MAX_32 6'h1F
`define PPC_MAX_64 6'h3F
`define PPC_TOT_16 7'h10
`define PPC_TOT_32 7'h20
`define PPC_TOT_64 7'h40
`define PPC_RST_BYTE 8'h00
`define PPC_RST_RES 2'h0
// Version and revision values are arbitrary.
`define PPC_CHIP_VER 8'h5A
`define PPC_CHIP_REV 8'hC3
`endif

/* core/ppc_pkg.sv */
// Types shared by the phase configuration port.
package ppc_pkg;
  typedef enum logic [1:0] {stIdle, stAddr, stData} ppc_state_type;
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
  } ppc_pll_type;
  typedef struct packed {
    logic [5:0] elements;
    logic [6:0] total;
  } ppc_phase_type;
endpackage : ppc_pkg

/* core/ppc_reg_mem.sv */
// Sixteen byte register store with a registered read port.
module ppc_reg_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [3:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [16];

  // Contents clear on reset so every register reads a defined value.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : ppc_reg_mem

/* core/pll_phase_config_port.sv */
// Indexed configuration port with phase adjuster and sync edge logic.
`include "ppc_defines.svh"

// How it works
// [R1] Index 4 bit 7 picks internal filter.
// [R2] Low index nibble increments per data byte.
// [R3] Upper index nibble never increments.
// [R4] Sync output delayed by selected element count.
// [R5] Resolution code sets element total and maximum.
// [R6] Host bypasses adjuster above 160 MHz.
// [R7] Resolution working copy loads on adjuster reset.
// [R8] Index 0 bit 2 picks sync edge.
// [R9] Index 8 commands reset adjuster or PLL.
// [R10] First write byte is index; reads continue.
module pll_phase_config_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic txnStart,
  input wire logic wrValid,
  input wire logic [7:0] wrByte,
  input wire logic rdReq,
  input wire logic pllLocked,
  input wire logic syncIn,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic loopFilterInternal,
  output logic syncFunctionOut,
  output logic pllResetPulse,
  output logic dpaResetPulse,
  output ppc_pkg::ppc_pll_type pllWorking,
  output ppc_pkg::ppc_phase_type phaseDelay
);
  import ppc_pkg::*;

  ppc_state_type state_reg;
  logic [7:0] index_reg;
  logic [7:0] edge_reg, offset_reg, resShadow_reg;
  ppc_pll_type pllShadow_reg;
  logic [1:0] resWorking_reg;
  logic [7:0] rdSel_reg;
  logic rdPend_reg;
  logic [7:0] memData;
  logic syncPrev_reg;
  logic [5:0] count_reg;
  logic busy_reg;
  logic dataWr, dataRd, memWr, syncEdge;
  logic [5:0] effOffset;

  function automatic logic [5:0] elemMax(input logic [1:0] res);
    case (res)
      `PPC_RES_32: elemMax = `PPC_MAX_32;
      `PPC_RES_64: elemMax = `PPC_MAX_64;
      default: elemMax = `PPC_MAX_16;
    endcase
  endfunction : elemMax

  function automatic logic [6:0] elemTotal(input logic [1:0] res);
    case (res)
      `PPC_RES_32: elemTotal = `PPC_TOT_32;
      `PPC_RES_64: elemTotal = `PPC_TOT_64;
      default: elemTotal = `PPC_TOT_16;
    endcase
  endfunction : elemTotal

  function automatic logic [7:0] nextIndex(input logic [7:0] idx);
    nextIndex = {idx[7:4], idx[3:0] + 4'h1};
  endfunction : nextIndex

  assign dataWr = wrValid && (state_reg == stData);
  assign dataRd = rdReq && !wrValid && (state_reg != stIdle);
  assign memWr = dataWr && (index_reg[7:4] == 4'h0) &&
                 (index_reg[3:0] <= `PPC_LAST_RW);

  // A transaction starts in the index phase; a read may start at once.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= stIdle;
    end else if (txnStart) begin
      state_reg <= stAddr;
    end else begin
      case (state_reg)
        stIdle: state_reg <= stIdle;
        stAddr: if (wrValid || rdReq) state_reg <= stData; // [R10]
        stData: state_reg <= stData;
        default: state_reg <= stIdle;
      endcase
    end
  end

  // Index byte loads whole pointer; data bytes bump only the low nibble.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_reg <= `PPC_RST_BYTE;
    end else if (!txnStart && wrValid && state_reg == stAddr) begin
      index_reg <= wrByte; // [R10]
    end else if (!txnStart && (dataWr || dataRd)) begin
      index_reg <= nextIndex(index_reg); // [R2] [R3]
    end
  end

  ppc_reg_mem u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(memWr),
    .wrAddr(index_reg[3:0]),
    .wrData(wrByte),
    .rdAddr(index_reg[3:0]),
    .rdData(memData)
  );

  // Shadow copies of the registers that steer logic here.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_reg <= `PPC_RST_BYTE;
      offset_reg <= `PPC_RST_BYTE;
      resShadow_reg <= `PPC_RST_BYTE;
      pllShadow_reg <= '0;
    end else if (memWr) begin
      case (index_reg)
        `PPC_IDX_EDGE: edge_reg <= wrByte;
        `PPC_IDX_PLL1: pllShadow_reg.cfg1 <= wrByte;
        `PPC_IDX_PLL2: pllShadow_reg.cfg2 <= wrByte;
        `PPC_IDX_PLL3: pllShadow_reg.cfg3 <= wrByte;
        `PPC_IDX_OFFSET: offset_reg <= wrByte;
        `PPC_IDX_RES: resShadow_reg <= wrByte; // [R7]
        default: edge_reg <= edge_reg;
      endcase
    end
  end

  // Commands at index 8 pulse resets and load working copies.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pllResetPulse <= 1'b0;
      dpaResetPulse <= 1'b0;
    end else begin
      pllResetPulse <= dataWr && index_reg == `PPC_IDX_RESET &&
                       wrByte[7:4] == `PPC_CMD_PLL; // [R9]
      dpaResetPulse <= dataWr && index_reg == `PPC_IDX_RESET &&
                       wrByte[3:0] == `PPC_CMD_DPA; // [R9]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resWorking_reg <= `PPC_RST_RES;
    end else if (dataWr && index_reg == `PPC_IDX_RESET &&
                 wrByte[3:0] == `PPC_CMD_DPA) begin
      resWorking_reg <= resShadow_reg[1:0]; // [R7] [R9]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pllWorking <= '0;
    end else if (dataWr && index_reg == `PPC_IDX_RESET &&
                 wrByte[7:4] == `PPC_CMD_PLL) begin
      pllWorking <= pllShadow_reg; // [R9]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loopFilterInternal <= 1'b0;
    end else if (memWr && index_reg == `PPC_IDX_OFFSET) begin
      loopFilterInternal <= wrByte[`PPC_BIT_FILTER]; // [R1]
    end
  end

  // Read path: memory cycle, then the answer byte one edge later.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdSel_reg <= `PPC_RST_BYTE;
      rdPend_reg <= 1'b0;
    end else begin
      rdSel_reg <= index_reg;
      rdPend_reg <= dataRd && !txnStart;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData <= `PPC_RST_BYTE;
    end else begin
      rdValid <= rdPend_reg;
      if (rdPend_reg) begin
        if (rdSel_reg[7:4] == 4'h0 && rdSel_reg[3:0] <= `PPC_LAST_RW) begin
          rdData <= memData;
        end else if (rdSel_reg == `PPC_IDX_VER) begin
          rdData <= `PPC_CHIP_VER;
        end else if (rdSel_reg == `PPC_IDX_REV) begin
          rdData <= `PPC_CHIP_REV;
        end else if (rdSel_reg == `PPC_IDX_STAT) begin
          rdData <= {6'h00, pllLocked, 1'b0};
        end else begin
          rdData <= `PPC_RST_BYTE;
        end
      end
    end
  end

  // Offset is held within the range of the working resolution.
  assign effOffset = (offset_reg[5:0] > elemMax(resWorking_reg)) ?
                     elemMax(resWorking_reg) : offset_reg[5:0]; // [R5]
  assign syncEdge = edge_reg[`PPC_BIT_EDGE] ?
                    (syncPrev_reg && !syncIn) :
                    (!syncPrev_reg && syncIn); // [R8]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phaseDelay.elements <= 6'h00;
      phaseDelay.total <= `PPC_TOT_16; // [R5]
    end else begin
      phaseDelay.elements <= effOffset; // [R4]
      phaseDelay.total <= elemTotal(resWorking_reg); // [R5]
    end
  end

  // Zero offset bypasses the delay, a useful setting for fast clocks.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncPrev_reg <= 1'b0;
      count_reg <= 6'h00;
      busy_reg <= 1'b0;
      syncFunctionOut <= 1'b0;
    end else begin
      syncPrev_reg <= syncIn;
      syncFunctionOut <= 1'b0;
      if (dpaResetPulse) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        count_reg <= count_reg - 6'h01;
        if (count_reg == 6'h01) begin
          busy_reg <= 1'b0;
          syncFunctionOut <= 1'b1; // [R4]
        end
      end else if (syncEdge) begin
        if (effOffset == 6'h00) begin
          syncFunctionOut <= 1'b1; // [R6]
        end else begin
          count_reg <= effOffset; // [R4]
          busy_reg <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_filter_select: assert property ( // [R1]
    memWr && index_reg == `PPC_IDX_OFFSET |=>
      loopFilterInternal == $past(wrByte[7]))
    else $error("Filter select did not follow index 4 bit 7.");
  chk_index_low_inc: assert property ( // [R2]
    !txnStart && dataWr |=> index_reg[3:0] == $past(index_reg[3:0]) + 4'h1)
    else $error("Low index nibble did not increment.");
  chk_index_upper_hold: assert property ( // [R3]
    !txnStart && (dataWr || dataRd) |=> $stable(index_reg[7:4]))
    else $error("Upper index nibble changed during data.");
  chk_index_first: assert property ( // [R10]
    !txnStart && wrValid && state_reg == stAddr |=>
      index_reg == $past(wrByte) && state_reg == stData)
    else $error("Index byte was not taken.");
  chk_delay_count: assert property ( // [R4]
    !busy_reg && !dpaResetPulse && syncEdge && effOffset == 6'h05 |=>
      !syncFunctionOut [*5] ##1 syncFunctionOut)
    else $error("Sync output delay wrong for five elements.");
  chk_offset_clamp: assert property ( // [R5]
    phaseDelay.elements <= phaseDelay.total[5:0] - 6'h01 ||
      phaseDelay.total == `PPC_TOT_64)
    else $error("Selected elements exceed resolution maximum.");
  chk_res_shadow: assert property ( // [R7]
    memWr && index_reg == `PPC_IDX_RES && !dpaResetPulse |=>
      $stable(resWorking_reg))
    else $error("Resolution write reached working copy.");
  chk_res_load: assert property ( // [R7]
    dataWr && index_reg == `PPC_IDX_RESET && wrByte[3:0] == `PPC_CMD_DPA
      |=> dpaResetPulse && resWorking_reg == $past(resShadow_reg[1:0]))
    else $error("Adjuster reset did not load resolution.");
  chk_pll_load: assert property ( // [R9]
    dataWr && index_reg == `PPC_IDX_RESET && wrByte[7:4] == `PPC_CMD_PLL
      |=> pllResetPulse && pllWorking == $past(pllShadow_reg))
    else $error("PLL reset did not load working copies.");
  chk_edge_wrong: assert property ( // [R8]
    !edge_reg[2] && syncPrev_reg && !syncIn && !busy_reg |=>
      !syncFunctionOut)
    else $error("Output followed the unselected sync edge.");
endmodule : pll_phase_config_port

/* verification/ppc_host_model.sv */
// Host model that drives transactions into the configuration port.
module ppc_host_model (
  input wire logic clock,
  output logic txnStart,
  output logic wrValid,
  output logic [7:0] wrByte,
  output logic rdReq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    txnStart = 1'b0;
    wrValid = 1'b0;
    wrByte = 8'h00;
    rdReq = 1'b0;
  end
  // One bus step; an idle data line carries a changing pattern.
  task automatic drive(input logic s, input logic w, input logic r,
      input logic [7:0] b);
    @(posedge clock);
    txnStart <= s;
    wrValid <= w;
    rdReq <= r;
    wrByte <= w ? b : 8'($urandom);
  endtask : drive
  // Every transaction restates its full index first.
  task automatic open(input logic [7:0] idx);
    drive(1'b1, 1'b0, 1'b0, 8'h00);
    drive(1'b0, 1'b1, 1'b0, idx);
  endtask : open
endmodule : ppc_host_model

/* verification/tb.sv */
// Self-checking bench for the phase configuration port.
`include "ppc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppc_pkg::*;
  logic clock, rst_n, txnStart, wrValid, rdReq, pllLocked, syncIn;
  logic rdValid, loopFilterInternal, syncFunctionOut;
  logic pllResetPulse, dpaResetPulse;
  logic [7:0] wrByte, rdData, cmd;
  ppc_pll_type pllWorking;
  ppc_phase_type phaseDelay;
  logic [7:0] expQ[$];
  logic [7:0] img[8];
  logic [1:0] codes[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [6:0] tots[4] = '{7'h20, 7'h40, 7'h10, 7'h10};
  logic [5:0] maxs[4] = '{6'h1F, 6'h3F, 6'h0F, 6'h0F};
  logic [6:0] prevTot;
  int miscompares = 0;
  int n_compared = 0;
  int n0, n1, nx;
  pll_phase_config_port pll_phase_config_port_i (.clock(clock),
    .rst_n(rst_n), .txnStart(txnStart), .wrValid(wrValid),
    .wrByte(wrByte), .rdReq(rdReq), .pllLocked(pllLocked),
    .syncIn(syncIn), .rdValid(rdValid), .rdData(rdData),
    .loopFilterInternal(loopFilterInternal),
    .syncFunctionOut(syncFunctionOut), .pllResetPulse(pllResetPulse),
    .dpaResetPulse(dpaResetPulse), .pllWorking(pllWorking),
    .phaseDelay(phaseDelay));
  ppc_host_model ppc_host_model_i (.clock(clock), .txnStart(txnStart),
    .wrValid(wrValid), .wrByte(wrByte), .rdReq(rdReq));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input string nm, input logic [23:0] seen,
      input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic step;
    ppc_host_model_i.drive(1'b0, 1'b0, 1'b0, 8'h00);
    #1;
  endtask : step
  task automatic put(input logic [7:0] b);
    ppc_host_model_i.drive(1'b0, 1'b1, 1'b0, b);
  endtask : put
  task automatic rd(input logic [7:0] exp);
    expQ.push_back(exp);
    ppc_host_model_i.drive(1'b0, 1'b0, 1'b1, 8'h00);
  endtask : rd
  task automatic sync_go(input logic lvl, output int n);
    n = 0;
    ppc_host_model_i.drive(1'b0, 1'b0, 1'b0, 8'h00);
    syncIn <= lvl;
    do begin
      @(posedge clock);
      n++;
    end while (syncFunctionOut !== 1'b1 && n < 20);
  endtask : sync_go
  // Each read answer is matched against the oldest expected byte.
  always @(posedge clock) begin
    if (rdValid === 1'b1)
      check("rdData", rdData, expQ.size() ? expQ.pop_front() : 8'hXX);
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    pllLocked = 1'b0;
    syncIn = 1'b0;
    void'($urandom(32));
    foreach (img[i]) img[i] = 8'($urandom);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    pllLocked <= 1'($urandom);
    #1;
    check("idle", {rdValid, syncFunctionOut, pllResetPulse}, 0);
    check("total", phaseDelay.total, `PPC_TOT_16);
    ppc_host_model_i.open(8'h00);
    foreach (img[i]) put(img[i]);
    ppc_host_model_i.open(8'h00);
    foreach (img[i]) rd(img[i]);
    rd(8'h00);
    ppc_host_model_i.open(8'h10);
    rd(`PPC_CHIP_VER);
    rd(`PPC_CHIP_REV);
    rd({6'h00, pllLocked, 1'b0});
    step();
    check("filter", loopFilterInternal, img[4][7]);
    // Lock status flips, and the pointer wraps inside the upper nibble.
    @(posedge clock);
    pllLocked <= ~pllLocked;
    ppc_host_model_i.open(8'h1F);
    rd(8'h00);
    rd(`PPC_CHIP_VER);
    rd(`PPC_CHIP_REV);
    rd({6'h00, pllLocked, 1'b0});
    step();
    prevTot = 7'h10;
    for (int k = 0; k < 4; k++) begin
      cmd = {k[0] ? 4'h5 : 4'h3, 4'hA};
      ppc_host_model_i.open(8'h05);
      put({6'h00, codes[k]});
      repeat (2) step();
      check("shadow", phaseDelay.total, prevTot);
      ppc_host_model_i.open(8'h08);
      put(cmd);
      step();
      check("pulses", {pllResetPulse, dpaResetPulse}, {k[0], 1'b1});
      step();
      check("total", phaseDelay.total, tots[k]);
      check("elem", phaseDelay.elements, img[4][5:0] > maxs[k] ?
        maxs[k] : img[4][5:0]);
      check("pll", pllWorking, k ? {img[1], img[2], img[3]} : 0);
      prevTot = tots[k];
    end
    // Clock is far below the bypass limit, so a nonzero offset is fine.
    for (int e = 0; e < 2; e++) begin
      ppc_host_model_i.open(8'h00);
      put({5'h00, e[0], 2'h0});
      ppc_host_model_i.open(8'h04);
      put(8'h00);
      sync_go(~e[0], n0);
      sync_go(e[0], nx);
      check("ignored", nx, 20);
      ppc_host_model_i.open(8'h04);
      put(8'h05);
      sync_go(~e[0], n1);
      check("delay", n1, n0 + 5);
    end
    repeat (4) step();
    check("pending", expQ.size(), 0);
    // A second reset in mid-run must drop the working copies again.
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check("rstPll", pllWorking, 0);
    check("rstTotal", phaseDelay.total, `PPC_TOT_16);
    check("rstFilter", loopFilterInternal, 0);
    finish_test();
  end
endmodule : tb
